//--- src/acob_pkg.sv
// Shared constants for the AC output channel register bank and its local bus
`default_nettype none
package acob_pkg;
   localparam int NumChannels = 8;
   localparam int AddrW = 8;
   localparam int DataW = 32;
   // Channel window offsets
   localparam logic [7:0] OffBoardId = 8'h04;
   localparam logic [7:0] OffFaultLamp = 8'h10;
   localparam logic [7:0] OffChanBase = 8'h40;
   localparam logic [7:0] OffChanLast = 8'h5C;
   localparam logic [7:0] OffChanStep = 8'h04;
   // Arbitrary id; the upper byte matches the fixed upper byte of the lamp register and the upper byte of the channel reset value
   localparam logic [15:0] BoardIdValue = 16'h21A6;
   localparam logic [15:0] FaultLampReset = 16'h2180;
   localparam logic [15:0] ChanReset = 16'h2100;
   localparam int OnBit = 7;
   localparam logic [15:0] UpperIdMask = 16'hFF00;
   // Controller register offsets on APB
   localparam logic [11:0] ApbCmd = 12'h000;
   localparam logic [11:0] ApbAddr = 12'h004;
   localparam logic [11:0] ApbWdata = 12'h008;
   localparam logic [11:0] ApbRdata = 12'h00C;
   localparam logic [11:0] ApbStatus = 12'h010;
   localparam logic [11:0] ApbBar0 = 12'h014;
   localparam logic [11:0] ApbBar2 = 12'h018;
   localparam int CmdGo = 0;
   localparam int CmdWrite = 1;
   localparam int CmdCfg = 2;
   localparam int CmdBeLo = 4;
   // Configuration-space offsets of the two window bases
   localparam logic [7:0] CfgBar0 = 8'h10;
   localparam logic [7:0] CfgBar2 = 8'h18;
   localparam logic [31:0] Bar0Reset = 32'h0000_0000;
   localparam logic [31:0] Bar2Reset = 32'h0000_0100;
   localparam logic [31:0] WindowMask = 32'hFFFF_FF00;

   function automatic logic [31:0] acob_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

//--- src/acob_local_if.sv
// Non-multiplexed local bus between the bridge controller and the channel logic
`timescale 1ns/1ns
`default_nettype none
interface acob_local_if;
   logic req;
   logic wr;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic ack;
   logic [31:0] rdata;
   modport bridge (output req, output wr, output addr, output wdata, output be,
                   input ack, input rdata);
   modport channel (input req, input wr, input addr, input wdata, input be,
                    output ack, output rdata);
endinterface
`default_nettype wire

//--- src/acob_channel_regs.sv
// Channel and fault-lamp registers in the logic device behind the bridge
`timescale 1ns/1ns
`default_nettype none
module acob_channel_regs
   import acob_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst,
   // Local bus
   acob_local_if.channel lb,
   // Outputs
   output logic [NumChannels-1:0] chanOn,
   output logic faultLamp
);
   logic [15:0] chan_ff [NumChannels];
   logic [15:0] lamp_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic hitChan;
   logic [2:0] chIdx;
   logic [31:0] merged;

   assign hitChan = lb.addr >= OffChanBase && lb.addr <= OffChanLast && lb.addr[1:0] == 2'b00;
   assign chIdx = 3'((lb.addr - OffChanBase) >> 2);

   always_comb begin
      merged = 32'h0000_0000;
      if (lb.addr == OffFaultLamp) begin
         merged = acob_merge({16'h0000, lamp_ff}, lb.wdata, lb.be);
      end else if (hitChan) begin
         merged = acob_merge({16'h0000, chan_ff[chIdx]}, lb.wdata, lb.be);
      end
   end

   // Hardwired defaults on any reset, never preloaded
   always_ff @(posedge clock) begin
      if (rst) begin
         lamp_ff <= FaultLampReset;
         for (int i = 0; i < NumChannels; i++) begin
            chan_ff[i] <= ChanReset;
         end
      end else if (lb.req && !ack_ff && lb.wr) begin
         if (lb.addr == OffFaultLamp) begin
            // Upper byte mirrors the board id and cannot be changed
            lamp_ff <= (FaultLampReset & UpperIdMask) | {8'h00, merged[7:0]};
         end else if (hitChan) begin
            chan_ff[chIdx] <= merged[15:0];
         end
      end
   end

   // One-cycle acknowledge; the id register ignores writes
   always_ff @(posedge clock) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= lb.req && !ack_ff;
         if (lb.req && !ack_ff && !lb.wr) begin
            if (lb.addr == OffBoardId) begin
               rdata_ff <= {16'h0000, BoardIdValue};
            end else if (lb.addr == OffFaultLamp) begin
               rdata_ff <= {16'h0000, lamp_ff};
            end else if (hitChan) begin
               rdata_ff <= {16'h0000, chan_ff[chIdx]};
            end else begin
               rdata_ff <= 32'h0000_0000;
            end
         end
      end
   end

   assign lb.ack = ack_ff;
   assign lb.rdata = rdata_ff;
   assign faultLamp = lamp_ff[OnBit];
   always_comb begin
      for (int i = 0; i < NumChannels; i++) begin
         chanOn[i] = chan_ff[i][OnBit];
      end
   end
endmodule
`default_nettype wire

//--- src/acob_bridge_ctrl.sv
// Target-only bridge controller: APB command registers to the local bus
// Notes on behaviour
// - Config group reached only by type 0 cycles
// - Config contents load from serial memory first
// - Window base 2 decodes channel registers
// - Window base 0 holds bridge local window
// - Software reads both window bases at run time
// - Channel registers live in external logic device
// - Local bus runs non-multiplexed address and data
// - Channel registers reset to hardwired defaults
// - Device is target only, never a master
// - Software leaves bridge local registers untouched
// - Writing a channel register changes the output
// - Bit 7 switches the channel on or off
// - Fault lamp lit after reset, one keeps it
// - Byte, word and longword accesses accepted
// - Channel window spans 256 bytes from base
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module acob_bridge_ctrl
   import acob_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial nonvolatile preload
   input wire logic preloadValid,
   input wire logic [31:0] preloadBar0,
   input wire logic [31:0] preloadBar2,
   // Local bus
   acob_local_if.bridge lb
);
   typedef enum logic [2:0] {
      StLoad = 3'b001,
      StIdle = 3'b010,
      StBusy = 3'b100
   } acob_state_t;

   acob_state_t state_ff;
   logic [31:0] bar0_ff, bar2_ff, addr_ff, wdata_ff, rdata_ff;
   logic wr_ff, err_ff, done_ff;
   logic [3:0] be_ff;
   logic apbWr, start, inWindow, loadDone;
   logic [2:0] preloadSync_ff;
   logic preloadSeen_ff;
   logic [31:0] prdata_ff, nxt_prdata;

   // Configuration offset decode, shared by the write and read paths
   function automatic logic acob_cfg_hit(input logic [31:0] a, input logic [7:0] off);
      return a[7:0] == off;
   endfunction

   // Preload-done comes from the serial memory loader, outside this clock domain
   always_ff @(posedge clock) begin
      if (rst) begin
         preloadSync_ff <= 3'h0;
      end else begin
         preloadSync_ff <= {preloadSync_ff[1:0], preloadValid};
      end
   end

   // A change is taken only once the second and third stages agree
   always_ff @(posedge clock) begin
      if (rst) begin
         preloadSeen_ff <= 1'b0;
      end else if (preloadSync_ff[1] == preloadSync_ff[2]) begin
         preloadSeen_ff <= preloadSync_ff[2];
      end
   end
   // Bases load once, on the first cycle the settled flag is seen
   assign loadDone = state_ff == StLoad && preloadSeen_ff;

   assign apbWr = psel && penable && pwrite;
   assign start = apbWr && paddr == ApbCmd && pwdata[CmdGo] && state_ff == StIdle;
   // Only the 256-byte channel window is forwarded; the bridge's local window is never served
   assign inWindow = (addr_ff & WindowMask) == bar2_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= StLoad;
      end else begin
         unique case (state_ff)
            StLoad: begin
               if (preloadSeen_ff) state_ff <= StIdle;
            end
            StIdle: if (start && !pwdata[CmdCfg] && inWindow) begin
               state_ff <= StBusy;
            end
            StBusy: if (lb.ack) state_ff <= StIdle;
         endcase
      end
   end

   // Window bases: preloaded, then changed only by configuration cycles
   always_ff @(posedge clock) begin
      if (rst) begin
         bar0_ff <= Bar0Reset;
         bar2_ff <= Bar2Reset;
      end else if (loadDone) begin
         bar0_ff <= preloadBar0 & WindowMask;
         bar2_ff <= preloadBar2 & WindowMask;
      end else if (start && pwdata[CmdCfg] && pwdata[CmdWrite]) begin
         // Type 0 configuration write reaches the bases; memory cycles never do
         if (acob_cfg_hit(addr_ff, CfgBar0)) begin
            bar0_ff <= wdata_ff & WindowMask;
         end
         if (acob_cfg_hit(addr_ff, CfgBar2)) begin
            bar2_ff <= wdata_ff & WindowMask;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         addr_ff <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         wr_ff <= 1'b0;
         be_ff <= 4'hF;
      end else if (apbWr && state_ff != StBusy) begin
         if (paddr == ApbAddr) addr_ff <= pwdata;
         if (paddr == ApbWdata) wdata_ff <= pwdata;
         if (paddr == ApbCmd) begin
            wr_ff <= pwdata[CmdWrite];
            be_ff <= pwdata[CmdBeLo +: 4];
         end
      end
   end

   // Completion, error and read result
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (state_ff == StBusy && lb.ack) begin
         if (!wr_ff) rdata_ff <= lb.rdata;
         done_ff <= 1'b1;
         err_ff <= 1'b0;
      end else if (start) begin
         done_ff <= 1'b0;
         if (pwdata[CmdCfg]) begin
            done_ff <= 1'b1;
            err_ff <= 1'b0;
            if (!pwdata[CmdWrite]) begin
               // Offsets other than the two bases read as zero
               if (acob_cfg_hit(addr_ff, CfgBar0)) begin
                  rdata_ff <= bar0_ff;
               end else if (acob_cfg_hit(addr_ff, CfgBar2)) begin
                  rdata_ff <= bar2_ff;
               end else begin
                  rdata_ff <= 32'h0000_0000;
               end
            end
         end else if (!inWindow) begin
            done_ff <= 1'b1;
            err_ff <= 1'b1; // Outside the channel window: no local cycle
         end
      end
   end

   // Local bus: full address and data lines at once, no multiplexing
   assign lb.req = state_ff == StBusy;
   assign lb.wr = wr_ff;
   assign lb.addr = addr_ff[7:0];
   assign lb.wdata = wdata_ff;
   assign lb.be = be_ff;

   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         unique case (paddr)
            ApbAddr: nxt_prdata = addr_ff;
            ApbWdata: nxt_prdata = wdata_ff;
            ApbRdata: nxt_prdata = rdata_ff;
            ApbStatus: nxt_prdata = {28'h0000000, err_ff, done_ff,
                                     state_ff == StBusy, state_ff == StLoad};
            ApbBar0: nxt_prdata = bar0_ff;
            ApbBar2: nxt_prdata = bar2_ff;
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Read data is captured in the setup cycle and stands through the access phase
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_ff <= nxt_prdata;
      end
   end
   assign prdata = prdata_ff;
endmodule
`default_nettype wire

//--- verif/acob_local_checker.sv
// Protocol checker for the local bus between bridge and channel logic
`timescale 1ns/1ns
`default_nettype none
module acob_local_checker
   import acob_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst,
   // Local bus
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] be,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_open;
      req && !ack;
   endsequence
   sequence s_rd_done;
      ack && !wr;
   endsequence
   property p_ack_next;
      s_open |=> ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse;
      ack |=> !ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_hold;
      s_open |=> req && $stable(addr) && $stable(wr) && $stable(wdata) && $stable(be);
   endproperty
   a_hold: assert property (p_hold) else $error("request moved");
   property p_release;
      ack |=> !req;
   endproperty
   a_release: assert property (p_release) else $error("req kept");
   property p_no_stray;
      ack |-> $past(req);
   endproperty
   a_no_stray: assert property (p_no_stray) else $error("ack without req");
   // Checked during reset itself, so the default disable is switched off
   property p_reset;
      disable iff (1'b0) rst |=> !req && !ack;
   endproperty
   a_reset: assert property (p_reset) else $error("bus busy in reset");
   property p_id;
      s_rd_done and (addr == OffBoardId) |-> rdata[15:0] == BoardIdValue;
   endproperty
   a_id: assert property (p_id) else $error("board id wrong");
   property p_reserved;
      s_rd_done and (addr >= 8'h60) |-> rdata == 32'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved not 0");
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Bench: APB-driven bridge joined to the channel registers
`timescale 1ns/1ns
`default_nettype none
module testbench
   import acob_pkg::*;
;
   localparam logic [31:0] bar0Val = 32'h0001_0000;
   localparam logic [31:0] bar2Val = 32'h0002_0000;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic preloadValid = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, st;
   logic pready, pslverr, faultLamp;
   logic [7:0] chanOn;
   int miscompares = 0;
   int totalChecks = 0;
   acob_local_if lbus();
   acob_bridge_ctrl u_acob_bridge_ctrl (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .preloadValid(preloadValid),
      .preloadBar0(bar0Val), .preloadBar2(bar2Val), .lb(lbus.bridge));
   acob_channel_regs u_acob_channel_regs (.clock(clock), .rst(rst), .lb(lbus.channel),
      .chanOn(chanOn), .faultLamp(faultLamp));
   acob_local_checker u_chk (.clock(clock), .rst(rst), .req(lbus.req), .wr(lbus.wr),
      .addr(lbus.addr), .wdata(lbus.wdata), .be(lbus.be), .ack(lbus.ack), .rdata(lbus.rdata));
   initial begin
      forever #5 clock = ~clock;
   end
   task end_sim;
      if (miscompares == 0 && totalChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Command byte: lanes in 7:4, config in 2, write in 1, go in 0
   task lcyc(input logic [7:0] cmd, input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, ApbAddr, a);
      apb(1'b1, ApbWdata, d);
      apb(1'b1, ApbCmd, {24'h0, cmd});
      apb(1'b0, ApbStatus, 32'h0);
      while (rd[1] !== 1'b0) apb(1'b0, ApbStatus, 32'h0);
      st = rd;
      apb(1'b0, ApbRdata, 32'h0);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, ApbStatus, 32'h0);
      chk("loading", rd & 32'h1, 32'h1);
      chk("lamp", 32'(faultLamp), 32'h1);
      preloadValid <= 1'b1;
      apb(1'b0, ApbStatus, 32'h0);
      while (rd[0] !== 1'b0) apb(1'b0, ApbStatus, 32'h0);
      apb(1'b0, ApbBar0, 32'h0);
      chk("bar0", rd, bar0Val);
      apb(1'b0, ApbBar2, 32'h0);
      chk("bar2", rd, bar2Val);
      lcyc(8'hF5, 32'(CfgBar0), 32'h0);
      chk("cfg0", rd, bar0Val);
      lcyc(8'hF5, 32'(CfgBar2), 32'h0);
      chk("cfg2", rd, bar2Val);
      lcyc(8'hF1, bar0Val, 32'h0);
      chk("localWin", st & 32'h8, 32'h8);
      lcyc(8'hF7, 32'(CfgBar0), 32'h0003_0000);
      apb(1'b0, ApbBar0, 32'h0);
      chk("cfgWr", rd, 32'h0003_0000);
      // A write to the id must not stick
      lcyc(8'h33, bar2Val + 32'h04, 32'h0);
      lcyc(8'hF1, bar2Val + 32'h04, 32'h0);
      chk("id", rd & 32'hFFFF, {16'h0, BoardIdValue});
      for (int i = 0; i < 8; i++) begin
         lcyc(8'h13, bar2Val + 32'h40 + 32'(4 * i), (i % 2 == 0) ? 32'h80 : 32'h0);
      end
      chk("chanOn", 32'(chanOn), 32'h55);
      for (int i = 0; i < 8; i++) begin
         lcyc(8'hF1, bar2Val + 32'h40 + 32'(4 * i), 32'h0);
         chk("chanRd", rd & 32'hFF, (i % 2 == 0) ? 32'h80 : 32'h0);
      end
      lcyc(8'h23, bar2Val + 32'h40, 32'h0);
      chk("laneMiss", 32'(chanOn), 32'h55);
      lcyc(8'h33, bar2Val + 32'h44, 32'h80);
      chk("wordWr", 32'(chanOn), 32'h57);
      lcyc(8'h13, bar2Val + 32'h10, 32'h0);
      chk("lampOff", 32'(faultLamp), 32'h0);
      lcyc(8'h13, bar2Val + 32'h10, 32'h80);
      lcyc(8'hF1, bar2Val + 32'h10, 32'h0);
      chk("lampRd", rd & 32'hFFFF, {16'h0, FaultLampReset});
      lcyc(8'hF1, bar2Val + 32'h80, 32'h0);
      chk("reserved", rd, 32'h0);
      lcyc(8'hF1, bar2Val + 32'h100, 32'h0);
      chk("outside", st & 32'h8, 32'h8);
      lcyc(8'h13, bar2Val + 32'h10, 32'h0);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk("rstChan", 32'(chanOn), 32'h0);
      chk("rstLamp", 32'(faultLamp), 32'h1);
      end_sim;
   end
   // A run takes a few hundred cycles; this bounds a stuck status poll
   initial begin
      #100000;
      miscompares++;
      end_sim;
   end
endmodule
`default_nettype wire
